// [src/fpbd_decoder.sv]
// Floating-point and branch instruction field decoder
`timescale 1ns/100ps
module fpbd_decoder
    import fpbd_pkg::*;
#(
    parameter int WORD_W = 32
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic insn_valid_i,
    input wire logic [31:0] insn_i,
    input wire logic [31:0] insn_addr_i,
    input wire logic [2:0] insn_class_i,
    input wire logic fp_store_form_i,
    output logic dec_valid_o,
    output logic [4:0] fp_source_a_select_o,
    output logic [4:0] fp_source_b_select_o,
    output logic [4:0] fp_source_c_select_o,
    output logic [4:0] fp_store_source_select_o,
    output logic [4:0] fp_target_select_o,
    output logic [7:0] fp_status_field_mask_o,
    output logic [31:0] fp_status_bit_mask_o,
    output logic [3:0] fp_status_imm_o,
    output logic [31:0] fp_status_data_o,
    output logic [6:0] supervisor_call_level_o,
    output logic [31:0] svc_handler_addr_o,
    output logic [31:0] branch_target_o,
    output logic link_write_o,
    output logic [31:0] link_data_o
);
    // Field positions assume a 32-bit word; refuse other widths early
    if (WORD_W != 32) begin : g_bad_width
        $error("fpbd_decoder: only 32-bit words are supported");
    end

    // Slice a field with bit 0 at the most significant end
    function automatic logic [31:0] fpbd_field(input logic [31:0] w,
                                               input int msb_n,
                                               input int lsb_n);
        logic [31:0] r;
        r = w >> (31 - lsb_n);
        r = r & ((32'h0000_0001 << (lsb_n - msb_n + 1)) - 32'h0000_0001);
        return r;
    endfunction

    logic is_branch;
    logic is_svc;
    logic [23:0] disp;
    logic [31:0] disp_ext;
    logic [6:0] level;
    logic [3:0] imm;
    logic [7:0] mask_raw;
    logic [7:0] mask_idx;
    logic [31:0] bit_mask;
    logic [31:0] next_status_data;
    logic [31:0] next_svc_addr;
    logic [31:0] next_target;
    logic [31:0] next_link;

    // Class decode and raw fields
    assign is_branch = insn_class_i == FPBD_CLS_BRANCH;
    assign is_svc = insn_class_i == FPBD_CLS_SVC;
    assign disp = 24'(fpbd_field(insn_i, FPBD_DISP_MSB, FPBD_DISP_LSB));
    assign level = 7'(fpbd_field(insn_i, FPBD_LEV_MSB, FPBD_LEV_LSB));
    assign imm = 4'(fpbd_field(insn_i, FPBD_IMM_MSB, FPBD_IMM_LSB));
    assign mask_raw = 8'(fpbd_field(insn_i, FPBD_MASK_MSB, FPBD_MASK_LSB));

    // Reverse so index 0 is insn bit 7, the first status field
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_rev
            assign mask_idx[g] = mask_raw[7-g];
        end
    endgenerate

    fpbd_mask_expand #(
        .FIELDS(8),
        .FIELD_W(4)
    ) u_mask (
        .mask_i(mask_idx),
        .bit_mask_o(bit_mask)
    );

    // Immediate replicated so each selected nibble takes the same data
    assign next_status_data = {8{imm}} & bit_mask;

    // Shift two, then sign extend to the full word
    assign disp_ext = {{6{disp[23]}}, disp, 2'b00};

    // Handler address: fixed or built from the level field
    always_comb begin
        if (insn_i[31-FPBD_ABS_BIT]) begin
            next_svc_addr = FPBD_SVC_FIXED_ADDR;
        end else begin
            next_svc_addr = {19'h00000, 1'b1, level, 5'h00};
        end
    end

    // Absolute form reuses the same bit that selects the fixed handler address
    always_comb begin
        if (insn_i[31-FPBD_ABS_BIT]) begin
            next_target = disp_ext;
        end else begin
            next_target = insn_addr_i + disp_ext;
        end
    end

    // Return address is always the following word
    assign next_link = insn_addr_i + FPBD_INSN_STEP;

    // Register selector fields
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fp_source_a_select_o <= FPBD_RESET_SEL;
            fp_source_b_select_o <= FPBD_RESET_SEL;
            fp_source_c_select_o <= FPBD_RESET_SEL;
            fp_store_source_select_o <= FPBD_RESET_SEL;
            fp_target_select_o <= FPBD_RESET_SEL;
        end else if (insn_valid_i) begin
            fp_source_a_select_o <=
                5'(fpbd_field(insn_i, FPBD_SRC_A_MSB, FPBD_SRC_A_LSB));
            fp_source_b_select_o <=
                5'(fpbd_field(insn_i, FPBD_SRC_B_MSB, FPBD_SRC_B_LSB));
            fp_source_c_select_o <=
                5'(fpbd_field(insn_i, FPBD_SRC_C_MSB, FPBD_SRC_C_LSB));
            fp_store_source_select_o <= fp_store_form_i ?
                5'(fpbd_field(insn_i, FPBD_TGT_MSB, FPBD_TGT_LSB)) :
                FPBD_RESET_SEL;
            fp_target_select_o <= fp_store_form_i ? FPBD_RESET_SEL :
                5'(fpbd_field(insn_i, FPBD_TGT_MSB, FPBD_TGT_LSB));
        end
    end

    // Status register update fields
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fp_status_field_mask_o <= 8'h00;
            fp_status_bit_mask_o <= FPBD_RESET_WORD;
            fp_status_imm_o <= 4'h0;
            fp_status_data_o <= FPBD_RESET_WORD;
        end else if (insn_valid_i) begin
            fp_status_field_mask_o <= mask_idx;
            fp_status_bit_mask_o <= bit_mask;
            fp_status_imm_o <= imm;
            fp_status_data_o <= next_status_data;
        end
    end

    // Control transfer fields
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            supervisor_call_level_o <= 7'h00;
            svc_handler_addr_o <= FPBD_RESET_WORD;
            branch_target_o <= FPBD_RESET_WORD;
        end else if (insn_valid_i) begin
            supervisor_call_level_o <= level;
            svc_handler_addr_o <= next_svc_addr;
            branch_target_o <= next_target;
        end
    end

    // Link register write; a cleared link bit never writes
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            link_write_o <= 1'b0;
            link_data_o <= FPBD_RESET_WORD;
            dec_valid_o <= 1'b0;
        end else begin
            dec_valid_o <= insn_valid_i;
            link_write_o <= insn_valid_i && (is_branch || is_svc)
                && insn_i[31-FPBD_LINK_BIT];
            if (insn_valid_i) begin
                link_data_o <= next_link;
            end
        end
    end

    // Checks
    link_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i && !insn_i[0] |=> !link_write_o)
        else $error("link written with link bit clear");
    link_branch_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i && is_branch && insn_i[0] |=>
        link_write_o && link_data_o == $past(insn_addr_i) + 32'h4)
        else $error("branch link write wrong");
    link_svc_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i && is_svc && insn_i[0] |=>
        link_write_o && link_data_o == $past(insn_addr_i) + 32'h4)
        else $error("svc link write wrong");
    svc_fixed_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i && insn_i[1] |=> svc_handler_addr_o == 32'h1FE0)
        else $error("fixed handler address wrong");
    svc_level_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i && !insn_i[1] |=>
        svc_handler_addr_o == {19'h0, 1'b1, $past(insn_i[11:5]), 5'h0})
        else $error("level handler address wrong");
    disp_rel_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i && !insn_i[1] |=> branch_target_o ==
        $past(insn_addr_i) + {{6{$past(insn_i[25])}},
        $past(insn_i[25:2]), 2'b00})
        else $error("relative branch target wrong");
    src_sel_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i |=> fp_source_a_select_o == $past(insn_i[20:16]) &&
        fp_source_b_select_o == $past(insn_i[15:11]) &&
        fp_source_c_select_o == $past(insn_i[10:6]))
        else $error("source selectors wrong");
    tgt_sel_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i && !fp_store_form_i |=>
        fp_target_select_o == $past(insn_i[25:21]))
        else $error("target selector wrong");
    mask_first_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        insn_valid_i |=> fp_status_bit_mask_o[31:28] == {4{$past(insn_i[24])}}
        && fp_status_data_o[3:0] == ($past(insn_i[17]) ?
        $past(insn_i[15:12]) : 4'h0))
        else $error("status mask or data wrong");

    branch_link_c: cover property (@(posedge mclk_i)
        insn_valid_i && is_branch && insn_i[0]);
    svc_abs_c: cover property (@(posedge mclk_i)
        insn_valid_i && is_svc && insn_i[1]);
    neg_disp_c: cover property (@(posedge mclk_i)
        insn_valid_i && is_branch && insn_i[25]);
endmodule

// [src/fpbd_pkg.sv]
// Shared field positions and constants for the fp/branch field decoder
package fpbd_pkg;
    // Field positions, big-endian bit numbering (0 = most significant)
    localparam int FPBD_MASK_MSB = 7;
    localparam int FPBD_MASK_LSB = 14;
    localparam int FPBD_SRC_A_MSB = 11;
    localparam int FPBD_SRC_A_LSB = 15;
    localparam int FPBD_SRC_B_MSB = 16;
    localparam int FPBD_SRC_B_LSB = 20;
    localparam int FPBD_SRC_C_MSB = 21;
    localparam int FPBD_SRC_C_LSB = 25;
    localparam int FPBD_TGT_MSB = 6;
    localparam int FPBD_TGT_LSB = 10;
    localparam int FPBD_IMM_MSB = 16;
    localparam int FPBD_IMM_LSB = 19;
    localparam int FPBD_LEV_MSB = 20;
    localparam int FPBD_LEV_LSB = 26;
    localparam int FPBD_DISP_MSB = 6;
    localparam int FPBD_DISP_LSB = 29;
    localparam int FPBD_ABS_BIT = 30;
    localparam int FPBD_LINK_BIT = 31;
    // Fixed handler address when the absolute bit is set
    localparam logic [31:0] FPBD_SVC_FIXED_ADDR = 32'h0000_1FE0;
    // Step from one instruction to the next
    localparam logic [31:0] FPBD_INSN_STEP = 32'h0000_0004;
    // Reset values
    localparam logic [31:0] FPBD_RESET_WORD = 32'h0000_0000;
    localparam logic [4:0] FPBD_RESET_SEL = 5'h00;
    // Instruction classes presented by the fetch path
    typedef enum logic [2:0] {
        FPBD_CLS_FP = 3'h1,
        FPBD_CLS_BRANCH = 3'h2,
        FPBD_CLS_SVC = 3'h4
    } fpbd_class_e;
endpackage

// [src/fpbd_mask_expand.sv]
// Expands the eight-bit status field mask into a per-bit write mask
`timescale 1ns/100ps
module fpbd_mask_expand
    import fpbd_pkg::*;
#(
    parameter int FIELDS = 8,
    parameter int FIELD_W = 4
) (
    input wire logic [FIELDS-1:0] mask_i,
    output logic [FIELDS*FIELD_W-1:0] bit_mask_o
);
    // The nibbles must tile the whole status word; refuse anything else
    if (FIELDS * FIELD_W != 32) begin : g_bad_cover
        $error("fpbd_mask_expand: fields must cover 32 bits");
    end

    // Mask index 0 (insn bit 7) covers status bits 00-03, the top nibble
    genvar g;
    generate
        for (g = 0; g < FIELDS; g++) begin : g_field
            assign bit_mask_o[(FIELDS-g)*FIELD_W-1 -: FIELD_W] =
                {FIELD_W{mask_i[g]}};
        end
    endgenerate
endmodule

// [testbench/fpbd_fetch_model.sv]
// Fetch-side model that presents instruction words to the decoder
`timescale 1ns/100ps
module fpbd_fetch_model (
    input wire logic mclk_i,
    input wire logic issue_i,
    input wire logic [31:0] word_i,
    input wire logic [31:0] addr_i,
    input wire logic [2:0] cls_i,
    input wire logic store_i,
    output logic insn_valid_o,
    output logic [31:0] insn_o,
    output logic [31:0] insn_addr_o,
    output logic [2:0] insn_class_o,
    output logic store_form_o
);
    // Idle cycles scramble the bus so a stale word is never mistaken
    always @(posedge mclk_i) begin
        insn_valid_o <= issue_i;
        insn_o <= issue_i ? word_i : ~insn_o;
        insn_addr_o <= issue_i ? addr_i : ~insn_addr_o;
        insn_class_o <= issue_i ? cls_i : ~insn_class_o;
        store_form_o <= issue_i ? store_i : ~store_form_o;
    end
    // Known values before the first edge
    initial begin
        insn_valid_o = 1'b0;
        insn_o = 32'h0;
        insn_addr_o = 32'h0;
        insn_class_o = 3'h1;
        store_form_o = 1'b0;
    end
endmodule

// [testbench/test_fpbd_decoder.sv]
// Self-checking bench for the fp/branch field decoder
`timescale 1ns/100ps
module test_fpbd_decoder;
    import fpbd_pkg::*;
    typedef struct packed {
        logic [4:0] a, b, c, st, tg;
        logic [7:0] m;
        logic [31:0] bm;
        logic [3:0] im;
        logic [31:0] dt;
        logic [6:0] lv;
        logic [31:0] ha, bt;
        logic lw;
        logic [31:0] ld;
    } fpbd_exp_s;
    logic mclk_i, reset_n_i, issue, store, insn_valid_i, fp_store_form_i;
    logic [31:0] word, addr, insn_i, insn_addr_i;
    logic [2:0] cls, insn_class_i;
    logic dec_valid_o, link_write_o;
    logic [4:0] fp_source_a_select_o, fp_source_b_select_o;
    logic [4:0] fp_source_c_select_o, fp_store_source_select_o;
    logic [4:0] fp_target_select_o;
    logic [7:0] fp_status_field_mask_o;
    logic [31:0] fp_status_bit_mask_o, fp_status_data_o, svc_handler_addr_o;
    logic [31:0] branch_target_o, link_data_o, r;
    logic [3:0] fp_status_imm_o;
    logic [6:0] supervisor_call_level_o;
    int err_total, num_checks, cycles;
    integer seed = 32'h7C66;
    fpbd_exp_s exp_q[$];
    fpbd_exp_s got;

    fpbd_fetch_model fetch (.mclk_i, .issue_i(issue), .word_i(word),
        .addr_i(addr), .cls_i(cls), .store_i(store),
        .insn_valid_o(insn_valid_i), .insn_o(insn_i),
        .insn_addr_o(insn_addr_i), .insn_class_o(insn_class_i),
        .store_form_o(fp_store_form_i));
    fpbd_decoder dut (.mclk_i, .reset_n_i, .insn_valid_i, .insn_i,
        .insn_addr_i, .insn_class_i, .fp_store_form_i, .dec_valid_o,
        .fp_source_a_select_o, .fp_source_b_select_o, .fp_source_c_select_o,
        .fp_store_source_select_o, .fp_target_select_o,
        .fp_status_field_mask_o, .fp_status_bit_mask_o, .fp_status_imm_o,
        .fp_status_data_o, .supervisor_call_level_o, .svc_handler_addr_o,
        .branch_target_o, .link_write_o, .link_data_o);

    // Doc bit n sits at word bit 31-n, so every field is reversed here
    function automatic fpbd_exp_s predict(logic [31:0] w, a, logic [2:0] c,
                                          logic s);
        fpbd_exp_s e;
        logic [31:0] disp;
        e.a = w[20:16];
        e.b = w[15:11];
        e.c = w[10:6];
        e.st = s ? w[25:21] : 5'h00;
        e.tg = s ? 5'h00 : w[25:21];
        for (int k = 0; k < 8; k++) begin
            e.m[k] = w[24-k];
            e.bm[31-4*k -: 4] = {4{w[24-k]}};
        end
        e.im = w[15:12];
        e.dt = {8{w[15:12]}} & e.bm;
        e.lv = w[11:5];
        e.ha = w[1] ? FPBD_SVC_FIXED_ADDR : {19'h0, 1'b1, w[11:5], 5'h00};
        disp = {{6{w[25]}}, w[25:2], 2'b00};
        e.bt = w[1] ? disp : a + disp;
        e.lw = (c == 3'h2 || c == 3'h4) && w[0];
        e.ld = a + FPBD_INSN_STEP;
        return e;
    endfunction

    // Wide enough for the joined compares, so no flag bit is cut off
    task automatic check(logic [64:0] seen, logic [64:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Present one word next edge and note what it should decode to
    task automatic send(logic [31:0] w, a, logic [2:0] c, logic s);
        @(posedge mclk_i);
        issue <= 1'b1;
        word <= w;
        addr <= a;
        cls <= c;
        store <= s;
        exp_q.push_back(predict(w, a, c, s));
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Every answer is matched against the oldest note
    always @(posedge mclk_i) begin
        if (reset_n_i && dec_valid_o) begin
            got = exp_q.pop_front();
            check(fp_source_a_select_o, got.a);
            check(fp_source_b_select_o, got.b);
            check(fp_source_c_select_o, got.c);
            check(fp_store_source_select_o, got.st);
            check(fp_target_select_o, got.tg);
            check(fp_status_field_mask_o, got.m);
            check(fp_status_bit_mask_o, got.bm);
            check({fp_status_imm_o, fp_status_data_o}, {got.im, got.dt});
            check(supervisor_call_level_o, got.lv);
            check(svc_handler_addr_o, got.ha);
            check(branch_target_o, got.bt);
            check({link_write_o, link_data_o}, {got.lw, got.ld});
        end else if (reset_n_i) begin
            check(link_write_o, 1'b0);
        end
    end

    // Clock and hang guard; the run needs well under a thousand cycles
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        mclk_i = 1'b0;
        reset_n_i = 1'b0;
        issue = 1'b0;
        store = 1'b0;
        word = 32'h0;
        addr = 32'h0;
        cls = 3'h1;
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        check({dec_valid_o, link_data_o, branch_target_o}, 65'h0);
        // Displacement extremes, both absolute settings, every class
        for (int j = 0; j < 24; j++)
            send((j[2] ? 32'h0200_0000 : 32'h01FF_FFFC) | j[1:0],
                 32'hFFFF_FFFC - j, 3'h1 << (j % 3), j[3]);
        // Walk one mask bit across every status nibble
        for (int k = 0; k < 8; k++)
            send(32'h0000_A000 | (32'h0002_0000 << k), 32'h100, 3'h1, 1'b0);
        // Random words back to back with occasional idle gaps
        repeat (300) begin
            r = $random(seed);
            send($random(seed), $random(seed), 3'h1 << (r[3:0] % 3), r[4]);
            if (r[7:5] == 3'h0) begin
                @(posedge mclk_i);
                issue <= 1'b0;
            end
        end
        @(posedge mclk_i);
        issue <= 1'b0;
        repeat (4) @(posedge mclk_i);
        check(exp_q.size(), 0);
        final_report();
    end
endmodule
